/* dbf_pkg.sv */
// shared constants, types and helpers for the bidirectional queue controller
// assumes the modules that import this package all run on one system clock
`default_nettype none
package dbf_pkg;
    localparam int DATA_W = 36;
    localparam int ADDR_W = 6;

    typedef logic [DATA_W-1:0] dbf_word_t;
    typedef logic [ADDR_W:0]   dbf_lvl_t;

    localparam dbf_lvl_t DEPTH_LVL  = 7'h40;
    localparam dbf_lvl_t OFS_SEL_11 = 7'h10;
    localparam dbf_lvl_t OFS_SEL_10 = 7'h0c;
    localparam dbf_lvl_t OFS_SEL_01 = 7'h08;
    localparam dbf_lvl_t OFS_SEL_00 = 7'h04;
    localparam dbf_lvl_t OFS_RST    = 7'h08;
    localparam logic     AF_RST     = 1'b1;
    localparam logic     MAIL_EMPTY = 1'b1;
    localparam logic     CS_IDLE    = 1'b1;

    // pointer difference; one spare bit keeps 64 apart from 0
    function automatic dbf_lvl_t dbf_level(input dbf_lvl_t wp, input dbf_lvl_t rp);
        return wp - rp;
    endfunction : dbf_level

    function automatic dbf_lvl_t dbf_offset_dec(input logic [1:0] fs);
        dbf_lvl_t v;
        v = OFS_SEL_00;
        unique case (fs)
            2'h3: v = OFS_SEL_11;
            2'h2: v = OFS_SEL_10;
            2'h1: v = OFS_SEL_01;
            2'h0: v = OFS_SEL_00;
        endcase
        return v;
    endfunction : dbf_offset_dec
endpackage : dbf_pkg
`default_nettype wire

/* dbf_q_if.sv */
// carrier between the port logic and one queue
// assumes all strobes are one system clock wide
`timescale 1ns/10ps
`default_nettype none
interface dbf_q_if;
    import dbf_pkg::*;
    logic      wr_edge;
    logic      wr_req;
    dbf_word_t wr_data;
    logic      rd_edge;
    logic      rd_req;
    dbf_word_t rd_data;
    logic      clear;
    dbf_lvl_t  offset;
    logic      full_n;
    logic      afull_n;
    logic      empty_n;
    logic      aempty_n;

    modport owner (output wr_edge, wr_req, wr_data, rd_edge, rd_req, clear, offset,
                   input  rd_data, full_n, afull_n, empty_n, aempty_n);
    modport queue (input  wr_edge, wr_req, wr_data, rd_edge, rd_req, clear, offset,
                   output rd_data, full_n, afull_n, empty_n, aempty_n);
endinterface : dbf_q_if
`default_nettype wire

/* dbf_sync2.sv */
// two-stage synchroniser for a bundle of pins
// assumes the bundle is sampled as one group; skew inside it is the pins' own
`timescale 1ns/10ps
`default_nettype none
module dbf_sync2 #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } dbf_sync_t;

    dbf_sync_t state_r;
    dbf_sync_t state_nxt;

    always_comb
    begin
        state_nxt.s1 = d;
        state_nxt.s2 = state_r.s1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_r <= {RST_VAL, RST_VAL};
        else
            state_r <= state_nxt;
    end

    assign q = state_r.s2;
endmodule : dbf_sync2
`default_nettype wire

/* dbf_queue.sv */
// one 64 x 36 queue with flags resynchronised at each side's port edges
// assumes wr_edge/rd_edge are one-cycle pulses of the two port clocks
`timescale 1ns/10ps
`default_nettype none
module dbf_queue (
    input  wire logic clk,
    input  wire logic rst,
    dbf_q_if.queue    q
);
    import dbf_pkg::*;

    typedef struct packed {
        dbf_lvl_t  wptr;
        dbf_lvl_t  rptr;
        dbf_lvl_t  rptr_w;
        dbf_lvl_t  wptr_r;
        dbf_word_t dout;
        logic      alive;
        logic      full_n;
        logic      afull_n;
        logic      empty_n;
        logic      aempty_n;
    } dbf_qstate_t;

    dbf_qstate_t state_r;
    dbf_qstate_t state_nxt;
    dbf_word_t   mem [2**ADDR_W];
    logic        wr_ok;
    logic        rd_ok;
    logic        clr;
    dbf_lvl_t    lvl_w;
    dbf_lvl_t    lvl_r;

    assign clr   = rst | q.clear;
    assign wr_ok = q.wr_edge & q.wr_req & state_r.full_n;
    assign rd_ok = q.rd_edge & q.rd_req & state_r.empty_n;

    always_comb
    begin
        lvl_w     = '0;
        lvl_r     = '0;
        state_nxt = state_r;
        if (clr)
        begin
            state_nxt         = '0;
            state_nxt.afull_n = AF_RST;
        end
        else
        begin
            // flag = stage two: copy of far pointer, then decode at the next edge
            if (q.wr_edge)
            begin
                state_nxt.wptr    = state_r.wptr + dbf_lvl_t'(wr_ok);
                state_nxt.rptr_w  = state_r.rptr;
                state_nxt.alive   = 1'b1;
                lvl_w             = dbf_level(state_nxt.wptr, state_r.rptr_w);
                state_nxt.full_n  = state_r.alive & (lvl_w != DEPTH_LVL);
                state_nxt.afull_n = lvl_w < (DEPTH_LVL - q.offset);
            end
            if (q.rd_edge)
            begin
                state_nxt.rptr     = state_r.rptr + dbf_lvl_t'(rd_ok);
                state_nxt.wptr_r   = state_r.wptr;
                if (rd_ok)
                    state_nxt.dout = mem[state_r.rptr[ADDR_W-1:0]];
                lvl_r              = dbf_level(state_r.wptr_r, state_nxt.rptr);
                // each write stores one whole word, so the last read drops empty_n
                state_nxt.empty_n  = lvl_r != '0;
                state_nxt.aempty_n = lvl_r > q.offset;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        state_r <= state_nxt;
        if (wr_ok && !clr)
            mem[state_r.wptr[ADDR_W-1:0]] <= q.wr_data;
    end

    assign q.rd_data  = state_r.dout;
    assign q.full_n   = state_r.full_n;
    assign q.afull_n  = state_r.afull_n;
    assign q.empty_n  = state_r.empty_n;
    assign q.aempty_n = state_r.aempty_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (clr);

    a_write_when_full: assert property (q.wr_edge && !state_r.full_n |=> $stable(state_r.wptr))
        else $error("write taken while full");
    a_empty_two_edges: assert property ($rose(state_r.empty_n) |-> $past(q.rd_edge) &&
                                        ($past(state_r.wptr_r) != $past(state_r.rptr)))
        else $error("empty flag rose without a staged write");
endmodule : dbf_queue
`default_nettype wire

/* dbf_ctrl.sv */
// top of the bidirectional queue controller: pin sampling, port decode,
// mailboxes, offset load and output drive
// assumes the port clocks run well below half the system clock and that
// pins are stable for a few system cycles after each port clock edge
`timescale 1ns/10ps
`default_nettype none
module dbf_ctrl (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              port_a_clock,
    input  wire logic              port_b_clock,
    input  wire logic              dev_reset_n,
    input  wire logic              offset_select_lo,
    input  wire logic              offset_select_hi,
    input  wire logic              port_a_chip_select_n,
    input  wire logic              port_a_write_not_read,
    input  wire logic              port_a_enable,
    input  wire logic              port_a_mail_select,
    input  wire dbf_pkg::dbf_word_t port_a_data_i,
    output logic [dbf_pkg::DATA_W-1:0] port_a_data_o,
    output logic                   port_a_data_oe,
    input  wire logic              port_b_chip_select_n,
    input  wire logic              port_b_write_not_read,
    input  wire logic              port_b_enable,
    input  wire logic              port_b_size_sel_lo,
    input  wire logic              port_b_size_sel_hi,
    input  wire dbf_pkg::dbf_word_t port_b_data_i,
    output logic [dbf_pkg::DATA_W-1:0] port_b_data_o,
    output logic                   port_b_data_oe,
    output logic                   port_a_full_flag,
    output logic                   port_a_almost_full_flag,
    output logic                   port_a_empty_flag,
    output logic                   port_a_almost_empty_flag,
    output logic                   port_b_full_flag,
    output logic                   port_b_almost_full_flag,
    output logic                   port_b_empty_flag,
    output logic                   port_b_almost_empty_flag,
    output logic                   a_to_b_mail_flag,
    output logic                   b_to_a_mail_flag
);
    import dbf_pkg::*;

    localparam int PW = DATA_W + 5;

    typedef struct packed {
        logic      port_a_clock_d;
        logic      port_b_clock_d;
        logic      dev_n_d;
        dbf_lvl_t  offset;
        dbf_word_t a_to_b_mailbox;
        dbf_word_t b_to_a_mailbox;
        logic      a_to_b_flag;
        logic      b_to_a_flag;
        dbf_word_t a_dout;
        dbf_word_t b_dout;
        logic      a_oe;
        logic      b_oe;
    } dbf_top_t;

    localparam dbf_top_t TOP_RST = '{
        port_a_clock_d:         1'b0,
        port_b_clock_d:         1'b0,
        dev_n_d:        1'b0,
        offset:         OFS_RST,
        a_to_b_mailbox: '0,
        b_to_a_mailbox: '0,
        a_to_b_flag:    MAIL_EMPTY,
        b_to_a_flag:    MAIL_EMPTY,
        a_dout:         '0,
        b_dout:         '0,
        a_oe:           1'b0,
        b_oe:           1'b0
    };

    dbf_top_t state_r;
    dbf_top_t state_nxt;

    // synchronised pins
    logic       a_clk_s;
    logic       a_cs_n_s;
    logic       a_wnr_s;
    logic       a_en_s;
    logic       a_mail_s;
    dbf_word_t  a_din_s;
    logic       b_clk_s;
    logic       b_cs_n_s;
    logic       b_wnr_s;
    logic       b_en_s;
    logic       b_siz_hi_s;
    logic       b_siz_lo_s;
    dbf_word_t  b_din_s;
    logic       dev_n_s;
    logic [1:0] fs_s;

    // decoded strobes
    logic a_edge;
    logic b_edge;
    logic a_sel;
    logic b_sel;
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic b_mail;
    logic dev_clear;
    logic dev_release;
    logic mab_wr;
    logic mab_rd;
    logic mba_wr;
    logic mba_rd;

    // clock pin and controls go through the same stages so they stay aligned
    dbf_sync2 #(
        .WIDTH   (PW),
        .RST_VAL ({1'b0, CS_IDLE, {(PW-2){1'b0}}})
    ) u_sync_a (
        .clk (clk),
        .rst (rst),
        .d   ({port_a_clock, port_a_chip_select_n, port_a_write_not_read,
               port_a_enable, port_a_mail_select, port_a_data_i}),
        .q   ({a_clk_s, a_cs_n_s, a_wnr_s, a_en_s, a_mail_s, a_din_s})
    );

    dbf_sync2 #(
        .WIDTH   (PW + 1),
        .RST_VAL ({1'b0, CS_IDLE, {(PW-1){1'b0}}})
    ) u_sync_b (
        .clk (clk),
        .rst (rst),
        .d   ({port_b_clock, port_b_chip_select_n, port_b_write_not_read,
               port_b_enable, port_b_size_sel_hi, port_b_size_sel_lo, port_b_data_i}),
        .q   ({b_clk_s, b_cs_n_s, b_wnr_s, b_en_s, b_siz_hi_s, b_siz_lo_s, b_din_s})
    );

    // device reset is asynchronous to everything; it is only seen resynchronised
    dbf_sync2 #(
        .WIDTH   (3),
        .RST_VAL (3'h0)
    ) u_sync_misc (
        .clk (clk),
        .rst (rst),
        .d   ({dev_reset_n, offset_select_hi, offset_select_lo}),
        .q   ({dev_n_s, fs_s})
    );

    assign a_edge      = a_clk_s & ~state_r.port_a_clock_d;
    assign b_edge      = b_clk_s & ~state_r.port_b_clock_d;
    assign a_sel       = a_edge & ~a_cs_n_s & a_en_s;
    assign b_sel       = b_edge & ~b_cs_n_s & b_en_s;
    assign a_wr        = a_sel & a_wnr_s;
    assign a_rd        = a_sel & ~a_wnr_s;
    assign b_wr        = b_sel & b_wnr_s;
    assign b_rd        = b_sel & ~b_wnr_s;
    assign b_mail      = b_siz_hi_s & b_siz_lo_s;
    assign dev_clear   = ~dev_n_s;
    assign dev_release = dev_n_s & ~state_r.dev_n_d;

    assign mab_wr = a_wr & a_mail_s & state_r.a_to_b_flag;
    assign mba_rd = a_rd & a_mail_s;
    assign mba_wr = b_wr & b_mail & state_r.b_to_a_flag;
    assign mab_rd = b_rd & b_mail;

    dbf_q_if ab_if ();
    dbf_q_if ba_if ();

    // a-to-b: written from port A, drained from port B
    assign ab_if.wr_edge = a_edge;
    assign ab_if.wr_req  = a_wr & ~a_mail_s;
    assign ab_if.wr_data = a_din_s;
    assign ab_if.rd_edge = b_edge;
    assign ab_if.rd_req  = b_rd & ~b_mail;
    assign ab_if.clear   = dev_clear;
    assign ab_if.offset  = state_r.offset;

    // b-to-a: written from port B, drained from port A
    assign ba_if.wr_edge = b_edge;
    assign ba_if.wr_req  = b_wr & ~b_mail;
    assign ba_if.wr_data = b_din_s;
    assign ba_if.rd_edge = a_edge;
    assign ba_if.rd_req  = a_rd & ~a_mail_s;
    assign ba_if.clear   = dev_clear;
    assign ba_if.offset  = state_r.offset;

    dbf_queue u_a_to_b_queue (
        .clk (clk),
        .rst (rst),
        .q   (ab_if.queue)
    );

    dbf_queue u_b_to_a_queue (
        .clk (clk),
        .rst (rst),
        .q   (ba_if.queue)
    );

    always_comb
    begin
        state_nxt         = state_r;
        state_nxt.port_a_clock_d  = a_clk_s;
        state_nxt.port_b_clock_d  = b_clk_s;
        state_nxt.dev_n_d = dev_n_s;
        if (dev_release)
            state_nxt.offset = dbf_offset_dec(fs_s);
        if (dev_clear)
        begin
            state_nxt.a_to_b_flag = MAIL_EMPTY;
            state_nxt.b_to_a_flag = MAIL_EMPTY;
        end
        else
        begin
            // new mail wins over a release in the same cycle, so none is lost
            if (mab_rd)
                state_nxt.a_to_b_flag = MAIL_EMPTY;
            if (mab_wr)
            begin
                state_nxt.a_to_b_flag    = ~MAIL_EMPTY;
                state_nxt.a_to_b_mailbox = a_din_s;
            end
            if (mba_rd)
                state_nxt.b_to_a_flag = MAIL_EMPTY;
            if (mba_wr)
            begin
                state_nxt.b_to_a_flag    = ~MAIL_EMPTY;
                state_nxt.b_to_a_mailbox = b_din_s;
            end
        end
        // drive follows the pins, not the enable or the port clock
        state_nxt.a_oe   = ~a_cs_n_s & ~a_wnr_s;
        state_nxt.b_oe   = ~b_cs_n_s & ~b_wnr_s;
        state_nxt.a_dout = a_mail_s ? state_r.b_to_a_mailbox : ba_if.rd_data;
        state_nxt.b_dout = b_mail ? state_r.a_to_b_mailbox : ab_if.rd_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_r <= TOP_RST;
        else
            state_r <= state_nxt;
    end

    assign port_a_data_o            = state_r.a_dout;
    assign port_a_data_oe           = state_r.a_oe;
    assign port_b_data_o            = state_r.b_dout;
    assign port_b_data_oe           = state_r.b_oe;
    assign a_to_b_mail_flag         = state_r.a_to_b_flag;
    assign b_to_a_mail_flag         = state_r.b_to_a_flag;
    assign port_a_full_flag         = ab_if.full_n;
    assign port_a_almost_full_flag  = ab_if.afull_n;
    assign port_b_empty_flag        = ab_if.empty_n;
    assign port_b_almost_empty_flag = ab_if.aempty_n;
    assign port_b_full_flag         = ba_if.full_n;
    assign port_b_almost_full_flag  = ba_if.afull_n;
    assign port_a_empty_flag        = ba_if.empty_n;
    assign port_a_almost_empty_flag = ba_if.aempty_n;

    // helper: writer edges seen since the last device reset, saturating at 2
    logic [1:0] a_edges_seen;
    logic [1:0] b_edges_seen;

    always_ff @(posedge clk)
    begin
        if (rst || dev_clear)
        begin
            a_edges_seen <= 2'h0;
            b_edges_seen <= 2'h0;
        end
        else
        begin
            if (a_edge && a_edges_seen != 2'h2)
                a_edges_seen <= a_edges_seen + 2'h1;
            if (b_edge && b_edges_seen != 2'h2)
                b_edges_seen <= b_edges_seen + 2'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_mail_flags: assert property (dev_clear |=> a_to_b_mail_flag && b_to_a_mail_flag)
        else $error("mail flags not released by device reset");
    a_reset_queue_flags: assert property (dev_clear |=>
        !port_a_full_flag && !port_b_full_flag &&
        !port_a_empty_flag && !port_b_empty_flag && !port_a_almost_empty_flag &&
        !port_b_almost_empty_flag && port_a_almost_full_flag && port_b_almost_full_flag)
        else $error("queue flags wrong during device reset");
    a_offset_load: assert property (dev_release |=> state_r.offset == dbf_offset_dec($past(fs_s)))
        else $error("offset not loaded from selects at reset release");
    a_offset_hold: assert property (!dev_release |=> $stable(state_r.offset))
        else $error("offset changed outside reset release");
    a_full_wait_a: assert property (!dev_clear && a_edges_seen != 2'h2 |-> !port_a_full_flag)
        else $error("port A full flag rose before second edge");
    a_full_rise_b: assert property (!dev_clear && b_edge && b_edges_seen == 2'h1 |=> port_b_full_flag)
        else $error("port B full flag late after reset");
    a_drive_port_a: assert property (a_cs_n_s || a_wnr_s |=> !port_a_data_oe)
        else $error("port A driven while not selected for read");
    a_drive_port_b: assert property (!b_cs_n_s && !b_wnr_s |=> port_b_data_oe)
        else $error("port B not driven while selected for read");
    a_mail_write: assert property (mab_wr && !dev_clear |=> !a_to_b_mail_flag &&
                                   state_r.a_to_b_mailbox == $past(a_din_s))
        else $error("mailbox write lost");
    a_mail_keep: assert property (!mba_wr |=> $stable(state_r.b_to_a_mailbox))
        else $error("mailbox changed without a write");
    a_mail_release: assert property (mab_rd && !mab_wr && !dev_clear |=> a_to_b_mail_flag)
        else $error("mailbox read did not release flag");
    a_no_xfer_off: assert property (a_edge && !a_en_s && !dev_clear |=>
                                    $stable(state_r.a_to_b_mailbox) && $stable(ba_if.rd_data))
        else $error("transfer while port A disabled");
    a_read_empty: assert property (ab_if.rd_edge && ab_if.rd_req && !ab_if.empty_n &&
                                   !dev_clear |=> $stable(ab_if.rd_data))
        else $error("read taken from empty queue");

    c_mail_pass: cover property (mab_wr ##[1:200] mab_rd);
    c_queue_full: cover property ($fell(port_b_full_flag) && !dev_clear);
    c_queue_data: cover property ($rose(port_b_empty_flag) ##[1:1000] ab_if.rd_req && b_edge);
endmodule : dbf_ctrl
`default_nettype wire

/* dbf_host_clk.sv */
// free-running port clock of one host on a port
// assumes the bench drives that port's pins itself
`timescale 1ns/10ps
`default_nettype none
module dbf_host_clk #(
    parameter int PHASE = 0
) (
    output logic pclk
);
    // runs between transfers too, as the ports expect a continuous clock
    initial
    begin
        pclk = 1'b0;
        #(PHASE);
        forever #40 pclk = ~pclk;
    end
endmodule : dbf_host_clk
`default_nettype wire

/* testbench.sv */
// self-checking bench for dbf_ctrl: queues, flags, offsets, mailboxes
// assumes dbf_host_clk makes both port clocks
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dbf_pkg::*;
    logic clk, rst, dev_reset_n, offset_select_lo, offset_select_hi, sz;
    logic [1:0] cs, w, en, s, mf;
    wire [1:0] pc;
    dbf_word_t di [2], mb [2], ro [2], q [2][$];
    logic [DATA_W-1:0] port_a_data_o, port_b_data_o;
    logic port_a_data_oe, port_b_data_oe, a_to_b_mail_flag, b_to_a_mail_flag;
    logic port_a_full_flag, port_a_almost_full_flag, port_a_empty_flag, port_a_almost_empty_flag;
    logic port_b_full_flag, port_b_almost_full_flag, port_b_empty_flag, port_b_almost_empty_flag;
    int x, m, seed = 38436, error_cnt = 0, n_tests = 0;
    dbf_host_clk #(.PHASE(3)) host_a (.pclk(pc[0]));
    dbf_host_clk #(.PHASE(29)) host_b (.pclk(pc[1]));
    dbf_ctrl uut (.clk, .rst, .port_a_clock(pc[0]), .port_b_clock(pc[1]), .dev_reset_n,
        .offset_select_lo, .offset_select_hi, .port_a_chip_select_n(cs[0]),
        .port_a_write_not_read(w[0]), .port_a_enable(en[0]), .port_a_mail_select(s[0]),
        .port_a_data_i(di[0]), .port_a_data_o, .port_a_data_oe, .port_b_chip_select_n(cs[1]),
        .port_b_write_not_read(w[1]), .port_b_enable(en[1]), .port_b_size_sel_lo(s[1]),
        .port_b_size_sel_hi(s[1] | sz), .port_b_data_i(di[1]), .port_b_data_o, .port_b_data_oe,
        .port_a_full_flag, .port_a_almost_full_flag, .port_a_empty_flag,
        .port_a_almost_empty_flag, .port_b_full_flag, .port_b_almost_full_flag,
        .port_b_empty_flag, .port_b_almost_empty_flag, .a_to_b_mail_flag, .b_to_a_mail_flag);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // per queue: full, almost full, empty, almost empty
    function automatic logic [3:0] qf(input int n);
        return {n < 64, n < 64 - x, n != 0, n > x};
    endfunction : qf
    function automatic logic [DATA_W-1:0] fl();
        return {port_b_full_flag, port_b_almost_full_flag, port_a_empty_flag,
            port_a_almost_empty_flag, port_a_full_flag, port_a_almost_full_flag,
            port_b_empty_flag, port_b_almost_empty_flag, b_to_a_mail_flag, a_to_b_mail_flag};
    endfunction : fl
    task automatic flags;
        chk("flags", {qf(q[1].size()), qf(q[0].size()), mf}, fl());
    endtask : flags
    // flags may lag up to two port edges on each side
    task automatic settle;
        repeat (3) @(posedge pc[0]);
        repeat (3) @(posedge pc[1]);
        repeat (5) @(negedge clk);
    endtask : settle
    task automatic op(input bit p, input logic wr, e, sl, input dbf_word_t d);
        @(negedge pc[p]);
        @(negedge clk);
        cs[p] = 1'b0;
        w[p] = wr;
        en[p] = e;
        s[p] = sl;
        di[p] = d;
        @(posedge pc[p]);
        repeat (4) @(negedge clk);
        en[p] = 1'b0;
        repeat (3) @(negedge clk);
        chk("oe", !wr, p ? port_b_data_oe : port_a_data_oe);
        if (e && wr && sl && mf[p])
            mb[p] = d;
        if (e && wr && sl)
            mf[p] = 1'b0;
        if (e && wr && !sl && q[p].size() < 64)
            q[p].push_back(d);
        if (e && !wr && sl)
            mf[!p] = 1'b1;
        if (e && !wr && !sl && q[!p].size() > 0)
            ro[p] = q[!p].pop_front();
        if (!wr)
            chk("data", sl ? mb[!p] : ro[p], p ? port_b_data_o : port_a_data_o);
    endtask : op
    initial
    begin
        for (int t = 0; t < 90000; t++)
            @(posedge clk);
        error_cnt++;
        summarize;
    end
    initial
    begin
        rst = 1'b1;
        dev_reset_n = 1'b0;
        sz = 1'b0;
        {offset_select_hi, offset_select_lo} = 2'h0;
        {cs, w, en, s} = 8'hf0;
        di[0] = '0;
        di[1] = '0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            x = 4 + 4 * k;
            {offset_select_hi, offset_select_lo} = k[1:0];
            @(negedge clk);
            dev_reset_n = 1'b0;
            cs = 2'h3;
            repeat (6) @(posedge pc[1]);
            chk("reset", 10'h113, fl());
            chk("oe", '0, {port_b_data_oe, port_a_data_oe});
            q[0].delete();
            q[1].delete();
            mf = 2'h3;
            @(negedge clk);
            dev_reset_n = 1'b1;
            settle;
            flags;
            if (k == 0)
            begin
                op(0, 1, 0, 1, 36'h1);
                op(0, 1, 1, 1, 36'ha5);
                op(0, 1, 1, 1, 36'h5a);
                flags;
                op(1, 0, 1, 1, '0);
                op(1, 1, 1, 1, 36'h3c);
                op(0, 0, 1, 1, '0);
                op(0, 0, 1, 1, '0);
                flags;
            end
            for (int i = 0; i < (k == 3 ? 65 : x + 2); i++)
            begin
                sz = 1'($random(seed));
                op(k[0], 1, 1, 0, DATA_W'({$random(seed), $random(seed)}));
                settle;
                flags;
            end
            m = q[k[0]].size();
            for (int i = 0; i <= m; i++)
            begin
                op(!k[0], 0, 1, 0, '0);
                settle;
                flags;
            end
            $display("test %0d done", k);
        end
        summarize;
    end
endmodule : testbench
`default_nettype wire
